// *** logic/bcdj_bcd_unit.sv ***
// Decimal correction of one byte after addition or subtraction
module bcdj_bcd_unit (
  input wire logic [7:0] value, // Byte to correct
  input wire logic carry_in, // Carry before correction
  input wire logic half_in, // Half carry before correction
  input wire logic sub_in, // Previous operation subtracted
  output logic [7:0] result, // Corrected byte
  output logic carry_out // Carry after correction
);

  logic [3:0] hi; // High digit
  logic [3:0] lo; // Low digit
  logic fix_lo; // Low digit needs correction
  logic fix_hi; // High digit needs correction
  logic [7:0] adj; // Addend

  // Correction selection
  always_comb begin
    hi = value[7:4];
    lo = value[3:0];
    if (!sub_in) begin
      // After addition: low fix may spill into a high digit of 9
      fix_lo = (lo > 4'h9) || half_in;
      fix_hi = carry_in || (hi > 4'h9) || (hi == 4'h9 && lo > 4'h9);
      adj = (fix_hi ? bcdj_pkg::ADD_HI : 8'h00)
          | (fix_lo ? bcdj_pkg::ADD_LO : 8'h00);
      carry_out = fix_hi;
    end else begin
      // After subtraction: carry stays as it was
      fix_lo = half_in && (lo >= 4'h6);
      fix_hi = carry_in && (hi >= (fix_lo ? 4'h6 : 4'h7));
      adj = 8'((fix_hi ? bcdj_pkg::SUB_HI : 8'h00)
          + (fix_lo ? bcdj_pkg::SUB_LO : 8'h00));
      carry_out = carry_in;
    end
    result = 8'(value + adj);
  end

endmodule // bcdj_bcd_unit

// *** logic/bcdj_core.sv ***
// Compare-jump, decimal correction and decrement executor with bus slave
// What this block does
// - Jump by displacement when destination minus source nonzero
// - Source pointer incremented by one always
// - Compare-jump leaves all flags unchanged
// - Compare-jump takes 18 cycles taken, 16 not
// - Source operand fetched through working register pointer
// - Correction yields two packed BCD digits
// - Result undefined for non-BCD input
// - After addition add 06, 60 or 66
// - After subtraction add FA, A0 or 9A
// - Carry set when high correction applies
// - Correction sets zero and sign from result
// - Correction keeps direction and half-carry flags
// - Indirect minus one leaves pointer register alone
// - Minus one sets zero flag on zero
// - Minus one sign flag follows bit 7
// - Minus one overflow from 80; C,D,H kept
module bcdj_core (
  input wire logic clock, // Core clock, 25 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire bcdj_pkg::bcdj_wb_req_s wb_req, // Bus request bundle
  output logic [bcdj_pkg::DAT_W-1:0] wb_dat_o, // Bus read data
  output logic wb_ack_o, // Bus acknowledge
  output logic busy, // Instruction in progress
  output logic done // One-cycle pulse at completion
);

  bcdj_pkg::bcdj_core_s r; // Current state
  bcdj_pkg::bcdj_core_s next_r; // Next state

  logic mem_we; // Register file write strobe
  logic [7:0] mem_addr; // Register file address
  logic [7:0] mem_wdata; // Register file write data
  logic [7:0] mem_rdata; // Register file read data
  logic [7:0] bcd_res; // Corrected byte
  logic bcd_carry; // Carry after correction
  logic [7:0] dec_res; // Decremented byte
  logic cmp_ne; // Compared operands differ
  logic [15:0] pc_jump; // Target when jumping
  logic [15:0] pc_step; // Next instruction
  logic bus_req; // New bus request present
  logic [bcdj_pkg::DAT_W-1:0] rd_val; // Register read mux
  logic [bcdj_pkg::DAT_W-1:0] wr_val; // Merged write word

  // Zero and sign flags from a result byte
  function automatic logic [7:0] set_zs(
    input logic [7:0] res,
    input logic [7:0] f
  );
    logic [7:0] o;
    o = f;
    o[bcdj_pkg::FLG_Z] = (res == 8'h00);
    o[bcdj_pkg::FLG_S] = res[7];
    return o;
  endfunction

  // General register file
  bcdj_gpr #(.AW(8), .DW(8)) u_gpr (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Decimal correction datapath
  bcdj_bcd_unit u_bcd (
    .value(mem_rdata),
    .carry_in(r.flags[bcdj_pkg::FLG_C]),
    .half_in(r.flags[bcdj_pkg::FLG_H]),
    .sub_in(r.flags[bcdj_pkg::FLG_D]),
    .result(bcd_res),
    .carry_out(bcd_carry)
  );

  // Shared arithmetic terms
  always_comb begin
    dec_res = 8'(mem_rdata - 8'h01);
    cmp_ne = (mem_rdata != r.sval);
    pc_step = 16'(r.pc + bcdj_pkg::LEN_CMP);
    pc_jump = 16'(pc_step + {{8{r.disp[7]}}, r.disp});
    bus_req = wb_req.cyc && wb_req.stb && !r.ack;
  end

  // Register read mux
  always_comb begin
    unique case (wb_req.adr)
      bcdj_pkg::OFS_CMD: rd_val = {29'h0, r.ind, r.op};
      bcdj_pkg::OFS_OPS: rd_val = {8'h00, r.disp, r.src, r.dst};
      bcdj_pkg::OFS_PC: rd_val = {16'h0000, r.pc};
      bcdj_pkg::OFS_FLAGS: rd_val = {24'h0, r.flags};
      bcdj_pkg::OFS_STAT: rd_val = {19'h0, r.cnt, 6'h00, r.taken,
                                    r.st != bcdj_pkg::ST_IDLE};
      bcdj_pkg::OFS_MADR: rd_val = {24'h0, r.madr};
      default: rd_val = '0; // Unmapped offsets read as zero; window reads return register file data
    endcase
    wr_val = bcdj_pkg::merge_bytes(rd_val, wb_req.dat, wb_req.sel);
  end

  // Next state: sequencer and bus slave
  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.done = 1'b0;
    mem_we = 1'b0;
    mem_addr = r.madr;
    mem_wdata = 8'h00;
    if (r.st != bcdj_pkg::ST_IDLE) begin
      next_r.cnt = 5'(r.cnt + 5'd1);
    end
    unique case (r.st)
      bcdj_pkg::ST_IDLE: begin
        // Bus owns the register file
      end
      bcdj_pkg::ST_PTR: begin
        // Fetch the pointer held in a working register
        mem_addr = (r.op == bcdj_pkg::OP_CMP) ? r.src : r.dst;
        next_r.st = bcdj_pkg::ST_OPND;
      end
      bcdj_pkg::ST_OPND: begin
        // Fetch the operand, through the pointer if indirect
        if (r.op == bcdj_pkg::OP_CMP || r.ind) begin
          mem_addr = mem_rdata;
        end else begin
          mem_addr = r.dst;
        end
        next_r.ptr = mem_addr;
        next_r.st = (r.op == bcdj_pkg::OP_CMP) ? bcdj_pkg::ST_DSTV
                                                : bcdj_pkg::ST_EXEC;
      end
      bcdj_pkg::ST_DSTV: begin
        // Hold the source, fetch the destination
        next_r.sval = mem_rdata;
        mem_addr = r.dst;
        next_r.st = bcdj_pkg::ST_EXEC;
      end
      bcdj_pkg::ST_EXEC: begin
        next_r.st = bcdj_pkg::ST_PAD;
        next_r.pc = 16'(r.pc + bcdj_pkg::LEN_ONE);
        unique case (r.op)
          bcdj_pkg::OP_CMP: begin
            // Pointer bump and branch; flags untouched
            mem_we = 1'b1;
            mem_addr = r.src;
            mem_wdata = 8'(r.ptr + 8'h01);
            next_r.taken = cmp_ne;
            next_r.pc = cmp_ne ? pc_jump : pc_step;
            next_r.total = cmp_ne ? bcdj_pkg::CYC_JMP
                                  : bcdj_pkg::CYC_NOJMP;
          end
          bcdj_pkg::OP_BCD: begin
            // Correct in place; overflow left as it was
            mem_we = 1'b1;
            mem_addr = r.ptr;
            mem_wdata = bcd_res;
            next_r.flags = set_zs(bcd_res, r.flags);
            next_r.flags[bcdj_pkg::FLG_C] = bcd_carry;
          end
          default: begin
            // Minus one in place; pointer register not written
            mem_we = 1'b1;
            mem_addr = r.ptr;
            mem_wdata = dec_res;
            next_r.flags = set_zs(dec_res, r.flags);
            next_r.flags[bcdj_pkg::FLG_V] =
              (mem_rdata == bcdj_pkg::MIN_NEG);
          end
        endcase
      end
      bcdj_pkg::ST_PAD: begin
        // Wait out the documented instruction time
        if (r.cnt == 5'(r.total - 5'd1)) begin
          next_r.st = bcdj_pkg::ST_IDLE;
          next_r.done = 1'b1;
        end
      end
      default: begin
        next_r.st = bcdj_pkg::ST_IDLE; // Illegal code recovery
      end
    endcase

    // Bus slave
    if (r.rd_pend) begin
      // Window read: memory data is now valid
      next_r.rd_pend = 1'b0;
      next_r.ack = 1'b1;
      next_r.dat = {24'h0, mem_rdata};
    end else if (bus_req) begin
      if (wb_req.adr == bcdj_pkg::OFS_MDAT) begin
        // Window access waits while an instruction runs
        if (r.st == bcdj_pkg::ST_IDLE) begin
          if (wb_req.we) begin
            mem_we = wb_req.sel[0];
            mem_wdata = wb_req.dat[7:0];
            next_r.ack = 1'b1;
            next_r.dat = '0;
          end else begin
            next_r.rd_pend = 1'b1;
          end
        end
      end else begin
        // All other offsets answer next cycle
        next_r.ack = 1'b1;
        next_r.dat = rd_val;
        if (wb_req.we && r.st == bcdj_pkg::ST_IDLE) begin
          unique case (wb_req.adr)
            bcdj_pkg::OFS_CMD: begin
              // Start: pointer fetch first unless direct single op
              if (wb_req.sel[0]) begin
                next_r.op = wr_val[bcdj_pkg::CMD_OP_LSB +: 2];
                next_r.ind = wr_val[bcdj_pkg::CMD_IND_BIT];
                next_r.cnt = 5'd0;
                next_r.total = bcdj_pkg::CYC_ONE;
                if (wr_val[bcdj_pkg::CMD_OP_LSB +: 2] == bcdj_pkg::OP_CMP
                    || wr_val[bcdj_pkg::CMD_IND_BIT]) begin
                  next_r.st = bcdj_pkg::ST_PTR;
                end else begin
                  next_r.st = bcdj_pkg::ST_OPND;
                end
              end
            end
            bcdj_pkg::OFS_OPS: begin
              next_r.dst = wr_val[7:0];
              next_r.src = wr_val[15:8];
              next_r.disp = wr_val[23:16];
            end
            bcdj_pkg::OFS_PC: next_r.pc = wr_val[15:0];
            bcdj_pkg::OFS_FLAGS: begin
              next_r.flags = wr_val[7:0] & bcdj_pkg::FLAG_MASK;
            end
            bcdj_pkg::OFS_MADR: next_r.madr = wr_val[7:0];
            default: begin
              // Read-only or unmapped: write ignored
            end
          endcase
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: bcdj_pkg::ST_IDLE, pc: bcdj_pkg::PC_RST,
             flags: bcdj_pkg::FLAGS_RST, total: bcdj_pkg::CYC_ONE,
             default: '0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Outputs
  always_comb begin
    wb_dat_o = r.dat;
    wb_ack_o = r.ack;
    busy = (r.st != bcdj_pkg::ST_IDLE);
    done = r.done;
  end

  // Busy cycle counter watched by the timing check
  logic [5:0] busy_len; // Cycles spent busy in last instruction
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_len <= 6'd0;
    end else if (ce) begin
      busy_len <= busy ? 6'(busy_len + 6'd1) : 6'd0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Operation steps
  sequence s_cmp_exec;
    ce && r.st == bcdj_pkg::ST_EXEC && r.op == bcdj_pkg::OP_CMP;
  endsequence
  sequence s_bcd_exec;
    ce && r.st == bcdj_pkg::ST_EXEC && r.op == bcdj_pkg::OP_BCD;
  endsequence
  sequence s_dec_exec;
    ce && r.st == bcdj_pkg::ST_EXEC && r.op == bcdj_pkg::OP_DEC;
  endsequence

  a_jump_target: assert property (
    s_cmp_exec ##0 cmp_ne |=> r.pc == $past(pc_jump))
    else $error("jump target wrong");
  a_no_jump_step: assert property (
    s_cmp_exec ##0 !cmp_ne |=> r.pc == $past(pc_step))
    else $error("fall-through address wrong");
  a_ptr_bump: assert property (
    s_cmp_exec |-> mem_we && mem_addr == r.src
                   && mem_wdata == 8'(r.ptr + 8'h01))
    else $error("source pointer not bumped");
  a_cmp_flags_kept: assert property (
    s_cmp_exec |=> $stable(r.flags) [*2])
    else $error("compare changed flags");
  a_cmp_cycle_count: assert property (
    (r.done && r.op == bcdj_pkg::OP_CMP) |->
      busy_len == (r.taken ? 6'd18 : 6'd16))
    else $error("compare cycle count wrong");
  a_bcd_add_carry: assert property (
    s_bcd_exec ##0 (!r.flags[bcdj_pkg::FLG_D] && mem_rdata[7:4] > 4'h9)
      |=> r.flags[bcdj_pkg::FLG_C])
    else $error("carry not set by high correction");
  a_bcd_keep_dh: assert property (
    s_bcd_exec |=> $stable(r.flags[bcdj_pkg::FLG_D])
                   && $stable(r.flags[bcdj_pkg::FLG_H]))
    else $error("correction changed D or H");
  a_dec_overflow: assert property (
    s_dec_exec |=> r.flags[bcdj_pkg::FLG_V] == ($past(mem_rdata) == 8'h80)
                   && $stable(r.flags[bcdj_pkg::FLG_C]))
    else $error("decrement overflow or carry wrong");
  a_dec_zero_sign: assert property (
    s_dec_exec |=> r.flags[bcdj_pkg::FLG_Z] == ($past(mem_rdata) == 8'h01)
      && r.flags[bcdj_pkg::FLG_S] == ($past(mem_rdata) == 8'h00
                                      || $past(mem_rdata) > 8'h80))
    else $error("decrement zero or sign wrong");

endmodule // bcdj_core

// *** logic/bcdj_gpr.sv ***
// General register file with registered read data
module bcdj_gpr #(
  parameter int AW = 8, // Address width
  parameter int DW = 8 // Data width
) (
  input wire logic clock, // Core clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic we, // Write strobe
  input wire logic [AW-1:0] addr, // Read and write address
  input wire logic [DW-1:0] wdata, // Write data
  output logic [DW-1:0] rdata // Read data, one cycle after addr
);

  logic [DW-1:0] mem [2**AW]; // Storage, no reset

  // Storage write
  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= mem[addr];
    end
  end

endmodule // bcdj_gpr

// *** logic/bcdj_pkg.sv ***
// Shared constants, types and helpers of the decimal adjust execution block
package bcdj_pkg;

  // Bus geometry
  localparam int ADR_W = 8; // Byte address width seen by the slave
  localparam int DAT_W = 32; // Bus data width
  localparam int SEL_W = 4; // Byte enables

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00; // Op select, write starts it
  localparam logic [7:0] OFS_OPS = 8'h04; // Operand addresses, displacement
  localparam logic [7:0] OFS_PC = 8'h08; // Program counter
  localparam logic [7:0] OFS_FLAGS = 8'h0C; // Condition flags
  localparam logic [7:0] OFS_STAT = 8'h10; // Busy, taken, cycle count
  localparam logic [7:0] OFS_MADR = 8'h14; // Register file window address
  localparam logic [7:0] OFS_MDAT = 8'h18; // Register file window data

  // Command fields
  localparam int CMD_OP_LSB = 0; // Two-bit operation code
  localparam int CMD_IND_BIT = 2; // Indirect operand through pointer

  // Operation codes
  localparam logic [1:0] OP_CMP = 2'h0; // Compare, bump pointer, jump if ne
  localparam logic [1:0] OP_BCD = 2'h1; // Decimal correction
  localparam logic [1:0] OP_DEC = 2'h2; // Minus one

  // Flag bit positions; bits 1 and 0 are reserved
  localparam int FLG_C = 7; // Carry
  localparam int FLG_Z = 6; // Zero
  localparam int FLG_S = 5; // Sign
  localparam int FLG_V = 4; // Overflow
  localparam int FLG_D = 3; // Last arithmetic was a subtraction
  localparam int FLG_H = 2; // Half carry
  localparam logic [7:0] FLAG_MASK = 8'hFC; // Implemented flag bits

  // Status fields
  localparam int STAT_BUSY_BIT = 0; // Instruction in progress
  localparam int STAT_TAKEN_BIT = 1; // Last compare jumped
  localparam int STAT_CNT_LSB = 8; // Cycle counter, five bits

  // Instruction timing in cycles
  localparam logic [4:0] CYC_JMP = 5'd18; // Compare with jump
  localparam logic [4:0] CYC_NOJMP = 5'd16; // Compare without jump
  localparam logic [4:0] CYC_ONE = 5'd4; // Single operand ops

  // Instruction lengths in bytes
  localparam logic [15:0] LEN_CMP = 16'h0003; // Three-byte compare
  localparam logic [15:0] LEN_ONE = 16'h0002; // Two-byte single op

  // Decimal correction addends
  localparam logic [7:0] ADD_LO = 8'h06; // Low digit after addition
  localparam logic [7:0] ADD_HI = 8'h60; // High digit after addition
  localparam logic [7:0] SUB_LO = 8'hFA; // Low digit after subtraction
  localparam logic [7:0] SUB_HI = 8'hA0; // High digit after subtraction
  localparam logic [7:0] MIN_NEG = 8'h80; // Most negative byte

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000; // Program counter
  localparam logic [7:0] FLAGS_RST = 8'h00; // Flags

  // Bus request bundle, published signal names
  typedef struct packed {
    logic cyc; // Cycle
    logic stb; // Strobe
    logic we; // Write enable
    logic [ADR_W-1:0] adr; // Byte address
    logic [SEL_W-1:0] sel; // Byte enables
    logic [DAT_W-1:0] dat; // Write data
  } bcdj_wb_req_s;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PTR, ST_OPND, ST_DSTV, ST_EXEC, ST_PAD
  } bcdj_state_e;

  // Whole state of the core
  typedef struct packed {
    bcdj_state_e st; // Sequencer
    logic [1:0] op; // Operation in progress
    logic ind; // Indirect operand
    logic [7:0] dst; // Destination register address
    logic [7:0] src; // Source pointer register address
    logic [7:0] disp; // Signed relative displacement
    logic [15:0] pc; // Program counter
    logic [7:0] flags; // Condition flags
    logic [4:0] cnt; // Cycles since start
    logic [4:0] total; // Cycles this instruction takes
    logic [7:0] ptr; // Fetched pointer or target address
    logic [7:0] sval; // Source operand
    logic taken; // Last compare jumped
    logic [7:0] madr; // Window address
    logic ack; // Bus acknowledge
    logic [DAT_W-1:0] dat; // Bus read data
    logic rd_pend; // Window read waiting for memory
    logic done; // Completion pulse
  } bcdj_core_s;

  // Byte-enable merge of a register word
  function automatic logic [DAT_W-1:0] merge_bytes(
    input logic [DAT_W-1:0] old_w,
    input logic [DAT_W-1:0] new_w,
    input logic [SEL_W-1:0] sel
  );
    logic [DAT_W-1:0] res;
    res = old_w;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// *** test/bcdj_core_tb.sv ***
// Self-checking bench of the compare-jump, decimal correction and decrement core
module bcdj_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0; // Core clock, 25 MHz
  logic rst_b = 1'b0; // Reset, active low
  logic ce = 1'b1; // Clock enable, running except for five cycles in the freeze test
  bcdj_pkg::bcdj_wb_req_s wb_req = '0; // Bus request bundle
  logic [31:0] wb_dat_o; // Bus read data
  logic wb_ack_o; // Bus acknowledge
  logic busy; // Instruction running
  logic done; // Completion pulse
  int error_cnt = 0; // Mismatches seen
  int samples_checked = 0; // Comparisons made
  int busy_n = 0; // Busy cycles of the last instruction
  int done_n = 0; // Done pulses of the last instruction

  // Device under test
  bcdj_core i_bcdj_core (
    .clock(clock),
    .rst_b(rst_b),
    .ce(ce),
    .wb_req(wb_req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy(busy),
    .done(done)
  );

  // Clock, 40 ns period
  initial begin
    forever #20 clock = ~clock;
  end

  // Busy and done counting, sampled mid-cycle where settled
  always @(negedge clock) begin
    if (busy === 1'b1) busy_n++;
    if (done === 1'b1) done_n++;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Word comparison with report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; held until ack is sampled high at a rising edge
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_req <= '0;
  endtask

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  // Register read
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  // Register file byte write through the window
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    wr(bcdj_pkg::OFS_MADR, {24'h0, a});
    wr(bcdj_pkg::OFS_MDAT, {24'h0, d});
  endtask

  // Register file byte read through the window
  task automatic mrd(input logic [7:0] a, output logic [31:0] q);
    wr(bcdj_pkg::OFS_MADR, {24'h0, a});
    rd(bcdj_pkg::OFS_MDAT, q);
  endtask

  // Start an instruction and wait for its completion pulse
  task automatic run(input logic [31:0] cmd);
    int n;
    busy_n = 0;
    done_n = 0;
    wr(bcdj_pkg::OFS_CMD, cmd);
    n = 0;
    while (done_n == 0 && n < 60) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    chk("done pulses", 32'h1, done_n);
  endtask

  // Reset values and an unmapped place
  task automatic t_reset();
    logic [31:0] q;
    rd(bcdj_pkg::OFS_PC, q);
    chk("pc reset", 32'h0, q);
    rd(bcdj_pkg::OFS_FLAGS, q);
    chk("flags reset", 32'h0, q);
    rd(8'h1C, q);
    chk("unmapped read", 32'h0, q);
  endtask

  // Compare against destination 02, source through pointer register 02
  task automatic t_cmp(input logic [7:0] ptr, input logic [7:0] sv,
                       input logic [7:0] disp);
    logic [31:0] q;
    logic jump;
    logic [15:0] pc_exp;
    jump = (sv != 8'h02);
    pc_exp = 16'h0103 + (jump ? {{8{disp[7]}}, disp} : 16'h0000);
    mwr(8'h01, 8'h02);
    mwr(8'h02, ptr);
    mwr(ptr, sv);
    wr(bcdj_pkg::OFS_PC, 32'h0100);
    wr(bcdj_pkg::OFS_FLAGS, 32'hA8);
    wr(bcdj_pkg::OFS_OPS, {8'h00, disp, 8'h02, 8'h01});
    run({29'h0, 1'b0, bcdj_pkg::OP_CMP});
    chk("cmp cycles", jump ? 32'd18 : 32'd16, busy_n);
    rd(bcdj_pkg::OFS_PC, q);
    chk("cmp pc", {16'h0, pc_exp}, q);
    mrd(8'h02, q);
    chk("cmp pointer", {24'h0, ptr + 8'h01}, q);
    rd(bcdj_pkg::OFS_FLAGS, q);
    chk("cmp flags", 32'hA8, q);
    rd(bcdj_pkg::OFS_STAT, q);
    chk("cmp taken", {19'h0, (jump ? 5'd18 : 5'd16), 6'h00, jump, 1'b0},
        q);
  endtask

  // Clock enable low stretches a minus one by the frozen cycles
  task automatic t_freeze();
    logic [31:0] q;
    mwr(8'h30, 8'h05);
    wr(bcdj_pkg::OFS_OPS, 32'h30);
    busy_n = 0;
    wr(bcdj_pkg::OFS_CMD, {29'h0, 1'b0, bcdj_pkg::OP_DEC});
    ce <= 1'b0;
    repeat (5) @(posedge clock);
    ce <= 1'b1;
    repeat (6) @(posedge clock);
    chk("freeze cycles", 32'd9, busy_n);
    mrd(8'h30, q);
    chk("freeze result", 32'h04, q);
  endtask

  // Decimal correction of byte 20, directly or through pointer 21
  task automatic t_bcd(input logic [7:0] v, input logic [7:0] fl,
                       input logic [7:0] exp, input logic cy, input logic ind);
    logic [31:0] q;
    logic [7:0] fexp;
    fexp = {cy, exp == 8'h00, exp[7], 1'b0, fl[3], fl[2], 2'b00};
    mwr(8'h20, v);
    mwr(8'h21, 8'h20);
    wr(bcdj_pkg::OFS_FLAGS, {24'h0, fl});
    wr(bcdj_pkg::OFS_OPS, {24'h0, ind ? 8'h21 : 8'h20});
    run({29'h0, ind, bcdj_pkg::OP_BCD});
    mrd(8'h20, q);
    chk("bcd result", {24'h0, exp}, q);
    rd(bcdj_pkg::OFS_FLAGS, q);
    chk("bcd flags", {24'h0, fexp}, q & 32'hEF);
  endtask

  // Minus one of byte 30, directly or through pointer 31
  task automatic t_dec(input logic [7:0] v, input logic ind);
    logic [31:0] q;
    logic [7:0] r;
    r = v - 8'h01;
    mwr(8'h30, v);
    mwr(8'h31, 8'h30);
    wr(bcdj_pkg::OFS_FLAGS, 32'hFC);
    wr(bcdj_pkg::OFS_OPS, {24'h0, ind ? 8'h31 : 8'h30});
    run({29'h0, ind, bcdj_pkg::OP_DEC});
    chk("dec cycles", 32'd4, busy_n);
    mrd(8'h30, q);
    chk("dec result", {24'h0, r}, q);
    mrd(8'h31, q);
    chk("dec pointer", 32'h30, q);
    rd(bcdj_pkg::OFS_FLAGS, q);
    chk("dec flags", {24'h0, 1'b1, r == 8'h00, r[7], v == 8'h80, 4'hC},
        q);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_cmp(8'h03, 8'h04, 8'hF0);
    t_cmp(8'h7F, 8'h02, 8'h10);
    t_cmp(8'hFF, 8'h00, 8'h7F);
    t_cmp(8'h10, 8'h03, 8'h80);
    t_bcd(8'h3C, 8'h00, 8'h42, 1'b0, 1'b0);
    t_bcd(8'hA5, 8'h00, 8'h05, 1'b1, 1'b1);
    t_bcd(8'h9F, 8'h00, 8'h05, 1'b1, 1'b0);
    t_bcd(8'h12, 8'h84, 8'h78, 1'b1, 1'b0);
    t_bcd(8'h92, 8'h04, 8'h98, 1'b0, 1'b0);
    t_bcd(8'h9A, 8'h00, 8'h00, 1'b1, 1'b0);
    t_bcd(8'h31, 8'h08, 8'h31, 1'b0, 1'b1);
    t_bcd(8'h0F, 8'h0C, 8'h09, 1'b0, 1'b0);
    t_bcd(8'h85, 8'h88, 8'h25, 1'b1, 1'b0);
    t_bcd(8'h6F, 8'h8C, 8'h09, 1'b1, 1'b0);
    t_dec(8'h80, 1'b1);
    t_dec(8'h01, 1'b0);
    t_dec(8'h00, 1'b1);
    t_dec(8'h10, 1'b0);
    t_freeze();
    conclude();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    conclude();
  end

endmodule // bcdj_core_tb
